// ==== gpcn_port.sv ====
// Parallel port with peripheral sharing, analog pin handling and change notice.
// Assumes one clock CLK, async active-low RSTN and synchronous pin inputs.
`include "gpcn_cfg.svh"

module gpcn_port #(
  parameter int WIDTH = 16,
  parameter int CHG_NUM = 8,
  parameter logic [WIDTH-1:0] IMPL_MASK = 16'hFFFF,
  parameter logic [WIDTH-1:0] INPUT_ONLY_MASK = 16'h0000,
  parameter logic [WIDTH-1:0] ANALOG_CAPABLE = 16'h00FF
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [`GPCN_ADDR_W-1:0] ADDR,
  input wire logic [WIDTH-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [WIDTH-1:0] RDATA,
  input wire logic [WIDTH-1:0] PIN_IN,
  output logic [WIDTH-1:0] PIN_OUT,
  output logic [WIDTH-1:0] PIN_OE,
  input wire logic [WIDTH-1:0] PERIPH_ACTIVE,
  input wire logic [WIDTH-1:0] PERIPH_DATA,
  output logic [WIDTH-1:0] ANALOG_SEL,
  input wire logic [CHG_NUM-1:0] CHG_IN,
  output logic [CHG_NUM-1:0] PULLUP_EN,
  output logic CHANGE_IRQ
);

  // Software-visible state
  logic [WIDTH-1:0] pin_direction_reg;
  logic [WIDTH-1:0] output_latch_reg;
  logic [WIDTH-1:0] analog_pin_config_reg;
  logic [CHG_NUM-1:0] change_irq_enable_reg;
  logic [CHG_NUM-1:0] weak_pullup_enable_reg;
  logic change_flag;
  logic [WIDTH-1:0] pin_sample;

  logic [WIDTH-1:0] next_pin_direction_reg;
  logic [WIDTH-1:0] next_output_latch_reg;
  logic [WIDTH-1:0] next_analog_pin_config_reg;
  logic [CHG_NUM-1:0] next_change_irq_enable_reg;
  logic [CHG_NUM-1:0] next_weak_pullup_enable_reg;
  logic next_change_flag;
  logic [WIDTH-1:0] next_rdata;
  logic [WIDTH-1:0] next_analog_sel;

  // Decoded access
  gpcn_pkg::gpcn_reg_sel_t sel;
  logic [CHG_NUM-1:0] chg_pulse;
  logic [WIDTH-1:0] pin_value_view;
  logic status_clear;

  // Address decode shared by reads and writes
  always_comb
  begin
    case (ADDR)
      `GPCN_OFF_DIR: sel = gpcn_pkg::GPCN_SEL_DIR;
      `GPCN_OFF_LATCH: sel = gpcn_pkg::GPCN_SEL_LATCH;
      `GPCN_OFF_PINVAL: sel = gpcn_pkg::GPCN_SEL_PINVAL;
      `GPCN_OFF_CHG_EN: sel = gpcn_pkg::GPCN_SEL_CHG_EN;
      `GPCN_OFF_PULLUP: sel = gpcn_pkg::GPCN_SEL_PULLUP;
      `GPCN_OFF_ANALOG: sel = gpcn_pkg::GPCN_SEL_ANALOG;
      `GPCN_OFF_STATUS: sel = gpcn_pkg::GPCN_SEL_STATUS;
      default: sel = gpcn_pkg::GPCN_SEL_NONE;
    endcase
  end

  // Pin-value view: unimplemented and analog pins read low
  always_comb
  begin
    pin_value_view = pin_sample & IMPL_MASK & ~analog_pin_config_reg;
  end

  // Register write decode
  always_comb
  begin
    next_pin_direction_reg = pin_direction_reg;
    next_output_latch_reg = output_latch_reg;
    next_analog_pin_config_reg = analog_pin_config_reg;
    next_change_irq_enable_reg = change_irq_enable_reg;
    next_weak_pullup_enable_reg = weak_pullup_enable_reg;
    status_clear = 1'b0;
    if (WR)
    begin
      case (sel)
        gpcn_pkg::GPCN_SEL_DIR:
          next_pin_direction_reg = WDATA & IMPL_MASK;
        gpcn_pkg::GPCN_SEL_LATCH:
          next_output_latch_reg = WDATA & IMPL_MASK;
        gpcn_pkg::GPCN_SEL_PINVAL:
          next_output_latch_reg = WDATA & IMPL_MASK;
        gpcn_pkg::GPCN_SEL_CHG_EN:
          next_change_irq_enable_reg = WDATA[CHG_NUM-1:0];
        gpcn_pkg::GPCN_SEL_PULLUP:
          next_weak_pullup_enable_reg = WDATA[CHG_NUM-1:0];
        gpcn_pkg::GPCN_SEL_ANALOG:
          next_analog_pin_config_reg = WDATA & IMPL_MASK & ANALOG_CAPABLE;
        gpcn_pkg::GPCN_SEL_STATUS:
          status_clear = WDATA[`GPCN_STAT_FLAG_BIT];
        default:
          status_clear = 1'b0;
      endcase
    end
  end

  // Configuration registers; all implemented pins come out of reset as inputs
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      pin_direction_reg <= IMPL_MASK;
      output_latch_reg <= '0;
      analog_pin_config_reg <= '0;
      change_irq_enable_reg <= '0;
      weak_pullup_enable_reg <= '0;
    end
    else
    begin
      pin_direction_reg <= next_pin_direction_reg;
      output_latch_reg <= next_output_latch_reg;
      analog_pin_config_reg <= next_analog_pin_config_reg;
      change_irq_enable_reg <= next_change_irq_enable_reg;
      weak_pullup_enable_reg <= next_weak_pullup_enable_reg;
    end
  end

  // Read mux; data stand only in the cycle after the strobe
  always_comb
  begin
    next_rdata = '0;
    if (RD)
    begin
      case (sel)
        gpcn_pkg::GPCN_SEL_DIR:
          next_rdata = pin_direction_reg & IMPL_MASK;
        gpcn_pkg::GPCN_SEL_LATCH:
          next_rdata = output_latch_reg & IMPL_MASK;
        gpcn_pkg::GPCN_SEL_PINVAL:
          next_rdata = pin_value_view;
        gpcn_pkg::GPCN_SEL_CHG_EN:
          next_rdata[CHG_NUM-1:0] = change_irq_enable_reg;
        gpcn_pkg::GPCN_SEL_PULLUP:
          next_rdata[CHG_NUM-1:0] = weak_pullup_enable_reg;
        gpcn_pkg::GPCN_SEL_ANALOG:
          next_rdata = analog_pin_config_reg;
        gpcn_pkg::GPCN_SEL_STATUS:
          next_rdata[`GPCN_STAT_FLAG_BIT] = change_flag;
        default:
          next_rdata = '0;
      endcase
    end
  end

  // Read data register
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      RDATA <= '0;
    end
    else
    begin
      RDATA <= next_rdata;
    end
  end

  // Pin levels sampled each clock for reading
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      pin_sample <= '0;
    end
    else
    begin
      pin_sample <= PIN_IN;
    end
  end

  // Converter offered only pins set analog and left as inputs
  always_comb
  begin
    next_analog_sel = analog_pin_config_reg & pin_direction_reg & IMPL_MASK;
  end

  // Analog select and pull-up outputs held in flops
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      ANALOG_SEL <= '0;
      PULLUP_EN <= '0;
    end
    else
    begin
      ANALOG_SEL <= next_analog_sel;
      PULLUP_EN <= next_weak_pullup_enable_reg;
    end
  end

  // One ownership mux pair per pin
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++)
    begin : g_pad
      gpcn_pad_cell #(
        .INPUT_ONLY(INPUT_ONLY_MASK[gi]),
        .IMPLEMENTED(IMPL_MASK[gi])
      ) u_pad (
        .clk(CLK),
        .rst_n(RSTN),
        .dir(pin_direction_reg[gi]),
        .latch(output_latch_reg[gi]),
        .periph_active(PERIPH_ACTIVE[gi]),
        .periph_data(PERIPH_DATA[gi]),
        .pad_out(PIN_OUT[gi]),
        .pad_oe(PIN_OE[gi])
      );
    end
  endgenerate

  // One change detector per notice input
  generate
    for (gi = 0; gi < CHG_NUM; gi++)
    begin : g_chg
      gpcn_change_cell u_chg (
        .clk(CLK),
        .rst_n(RSTN),
        .pin(CHG_IN[gi]),
        .enable(change_irq_enable_reg[gi]),
        .change(chg_pulse[gi])
      );
    end
  endgenerate

  // Shared change flag; a new change wins over a clear in the same cycle
  always_comb
  begin
    next_change_flag = (change_flag & ~status_clear) | (|chg_pulse);
  end

  // Change flag and interrupt request
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      change_flag <= 1'b0;
      CHANGE_IRQ <= 1'b0;
    end
    else
    begin
      change_flag <= next_change_flag;
      CHANGE_IRQ <= next_change_flag;
    end
  end

endmodule : gpcn_port

// ==== gpcn_cfg.svh ====
// Register offsets, reset values and field positions for the port block.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef GPCN_CFG_SVH
`define GPCN_CFG_SVH

// Register offsets on the plain register port
`define GPCN_ADDR_W 8
`define GPCN_OFF_DIR 8'h00
`define GPCN_OFF_LATCH 8'h04
`define GPCN_OFF_PINVAL 8'h08
`define GPCN_OFF_CHG_EN 8'h0C
`define GPCN_OFF_PULLUP 8'h10
`define GPCN_OFF_ANALOG 8'h14
`define GPCN_OFF_STATUS 8'h18

// Field positions and reset values
`define GPCN_STAT_FLAG_BIT 0
`define GPCN_DIR_INPUT 1'b1
`define GPCN_ZERO_BIT 1'b0

`endif

// ==== gpcn_pkg.sv ====
// Types used by the port block's address decode.
// Assumes nothing beyond a SystemVerilog compiler.
package gpcn_pkg;

  // Register selected by a bus address
  typedef enum logic [2:0] {
    GPCN_SEL_NONE,
    GPCN_SEL_DIR,
    GPCN_SEL_LATCH,
    GPCN_SEL_PINVAL,
    GPCN_SEL_CHG_EN,
    GPCN_SEL_PULLUP,
    GPCN_SEL_ANALOG,
    GPCN_SEL_STATUS
  } gpcn_reg_sel_t;

endpackage : gpcn_pkg

// ==== gpcn_pad_cell.sv ====
// One pin's output ownership mux pair with registered pad controls.
// Assumes synchronous inputs on CLK and an active-low async reset.
`include "gpcn_cfg.svh"

module gpcn_pad_cell #(
  parameter bit INPUT_ONLY = 1'b0,
  parameter bit IMPLEMENTED = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic dir,
  input wire logic latch,
  input wire logic periph_active,
  input wire logic periph_data,
  output logic pad_out,
  output logic pad_oe
);

  logic owned;
  logic next_pad_out;
  logic next_pad_oe;

  // Peripheral owns the pad only while it drives; input-only sharers never do
  always_comb
  begin
    owned = periph_active & ~INPUT_ONLY;
    next_pad_out = owned ? periph_data : latch;
    next_pad_oe = owned | ~dir;
    if (!IMPLEMENTED)
    begin
      next_pad_out = `GPCN_ZERO_BIT;
      next_pad_oe = `GPCN_ZERO_BIT;
    end
  end

  // Pad controls held in flops
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pad_out <= `GPCN_ZERO_BIT;
      pad_oe <= `GPCN_ZERO_BIT;
    end
    else
    begin
      pad_out <= next_pad_out;
      pad_oe <= next_pad_oe;
    end
  end

endmodule : gpcn_pad_cell

// ==== gpcn_change_cell.sv ====
// One change notice input: captured value and registered change pulse.
// Assumes the input is synchronous to clk.
`include "gpcn_cfg.svh"

module gpcn_change_cell (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  input wire logic enable,
  output logic change
);

  logic last;
  logic next_last;
  logic next_change;

  // Compare with captured value, then capture the new one
  always_comb
  begin
    next_change = enable & (pin ^ last);
    next_last = pin;
  end

  // Capture stays frozen while the clock is stopped, so the mismatch survives
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      last <= `GPCN_ZERO_BIT;
      change <= `GPCN_ZERO_BIT;
    end
    else
    begin
      last <= next_last;
      change <= next_change;
    end
  end

endmodule : gpcn_change_cell

// ==== gpcn_port_chk.sv ====
// Checker for the port block, bound to gpcn_port.
// Assumes the design's register and pad timing.
`include "gpcn_cfg.svh"

module gpcn_chk #(
  parameter int WIDTH = 16,
  parameter int CHG_NUM = 8,
  parameter logic [WIDTH-1:0] IMPL_MASK = 16'hFFFF,
  parameter logic [WIDTH-1:0] INPUT_ONLY_MASK = 16'h0000
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [`GPCN_ADDR_W-1:0] ADDR,
  input wire logic [WIDTH-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [WIDTH-1:0] RDATA,
  input wire logic [WIDTH-1:0] PIN_OUT,
  input wire logic [WIDTH-1:0] PIN_OE,
  input wire logic [WIDTH-1:0] PERIPH_ACTIVE,
  input wire logic [WIDTH-1:0] PERIPH_DATA,
  input wire logic [WIDTH-1:0] ANALOG_SEL,
  input wire logic [CHG_NUM-1:0] CHG_IN,
  input wire logic [CHG_NUM-1:0] PULLUP_EN,
  input wire logic CHANGE_IRQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // Pins a peripheral may take over
  wire logic [WIDTH-1:0] own = PERIPH_ACTIVE & IMPL_MASK & ~INPUT_ONLY_MASK;

  property p_per_oe;
    $past(RSTN) |-> (PIN_OE & $past(own)) == $past(own);
  endproperty
  a_per_oe: assert property (p_per_oe) else $error("peripheral pin not driven");
  property p_per_out;
    $past(RSTN) |-> ((PIN_OUT ^ $past(PERIPH_DATA)) & $past(own)) == '0;
  endproperty
  a_per_out: assert property (p_per_out) else $error("peripheral data lost");
  property p_unimpl;
    ((PIN_OE | ANALOG_SEL | RDATA) & ~IMPL_MASK) == '0;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("missing bit active");
  property p_rd_idle;
    !$past(RD) |-> RDATA == '0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_ana_rd;
    $past(RD) && $past(ADDR) == `GPCN_OFF_PINVAL |-> (RDATA & $past(ANALOG_SEL)) == '0;
  endproperty
  a_ana_rd: assert property (p_ana_rd) else $error("analog pin read nonzero");
  property p_irq_hold;
    $past(CHANGE_IRQ) && !($past(WR) && $past(ADDR) == `GPCN_OFF_STATUS && $past(WDATA[0])) |-> CHANGE_IRQ;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("change request dropped");
  property p_irq_cause;
    $rose(CHANGE_IRQ) |-> $past(CHG_IN, 2) != $past(CHG_IN, 3) || $past(WR, 3);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("change request without change");
  property p_pullup;
    $past(WR) && $past(ADDR) == `GPCN_OFF_PULLUP |-> PULLUP_EN == $past(WDATA[CHG_NUM-1:0]);
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up enables wrong");
  // Main scenarios reached
  c_irq: cover property ($rose(CHANGE_IRQ));
  c_per: cover property (|(PIN_OE & PERIPH_ACTIVE));
  c_rd: cover property ($past(RD) && RDATA != '0);
endmodule : gpcn_chk

bind gpcn_port gpcn_chk #(.WIDTH(WIDTH), .CHG_NUM(CHG_NUM), .IMPL_MASK(IMPL_MASK),
  .INPUT_ONLY_MASK(INPUT_ONLY_MASK)) chk (.CLK, .RSTN, .ADDR, .WDATA, .WR, .RD, .RDATA,
  .PIN_OUT, .PIN_OE, .PERIPH_ACTIVE, .PERIPH_DATA, .ANALOG_SEL, .CHG_IN, .PULLUP_EN, .CHANGE_IRQ);

// ==== gpcn_pin_model.sv ====
// Pad model: pin levels from drivers, pull-ups and outside lines.
// Assumes 16 pins, pins 0..7 wired to the change inputs.
module gpcn_pin_model (
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe,
  input wire logic [7:0] pullup_en,
  input wire logic [15:0] ext_lvl,
  output logic [15:0] pin_in,
  output logic [7:0] chg_in
);
  // Driven pins show the pad, others pull-up or outside level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ({8'h00, pullup_en} | ext_lvl));
  assign chg_in = pin_in[7:0];
endmodule : gpcn_pin_model

// ==== gpcn_port_tb_top.sv ====
// Self-checking bench for the port block with pad model.
// Assumes design, checker and pad model compiled first.
`include "gpcn_cfg.svh"

module gpcn_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] IMPL = 16'h7FFF;
  logic CLK = 1'b0;
  logic clk_run = 1'b1;
  logic RSTN = 1'b0;
  logic [7:0] ADDR = 8'h00;
  logic [15:0] WDATA = 16'h0000;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [15:0] PERIPH_ACTIVE = 16'h0000;
  logic [15:0] PERIPH_DATA = 16'h0000;
  logic [15:0] ext_lvl = 16'h0000;
  logic [15:0] RDATA, PIN_IN, PIN_OUT, PIN_OE, ANALOG_SEL, rd_val;
  logic [7:0] CHG_IN, PULLUP_EN;
  logic CHANGE_IRQ;
  int error_cnt = 0;
  int num_checks = 0;

  // Clock, frozen while sleeping
  always #2 CLK = clk_run ? ~CLK : CLK;

  gpcn_port #(.IMPL_MASK(IMPL), .INPUT_ONLY_MASK(16'h4000)) dut (.CLK, .RSTN, .ADDR, .WDATA,
    .WR, .RD, .RDATA, .PIN_IN, .PIN_OUT, .PIN_OE, .PERIPH_ACTIVE, .PERIPH_DATA, .ANALOG_SEL,
    .CHG_IN, .PULLUP_EN, .CHANGE_IRQ);
  gpcn_pin_model pads (.pin_out(PIN_OUT), .pin_oe(PIN_OE), .pullup_en(PULLUP_EN),
    .ext_lvl(ext_lvl), .pin_in(PIN_IN), .chg_in(CHG_IN));

  // Compare and count
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  // Verdict and end of run
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  // Register write, then one idle cycle
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
    @(posedge CLK);
  endtask : wr

  // Register read, data taken in the slot after
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 d = RDATA;
    @(posedge CLK);
  endtask : rd

  // Bounded wait for the change request
  task automatic wait_irq();
    for (int n = 0; n < 12 && CHANGE_IRQ !== 1'b1; n++)
      @(posedge CLK);
    check({15'h0000, CHANGE_IRQ}, 16'h0001);
    if (CHANGE_IRQ !== 1'b1)
      final_report();
  endtask : wait_irq

  // Reset state and unmapped read
  task automatic t_reset();
    rd(`GPCN_OFF_DIR, rd_val);
    check(rd_val, IMPL);
    check(PIN_OE, 16'h0000);
    rd(8'h1C, rd_val);
    check(rd_val, 16'h0000);
  endtask : t_reset

  // Latch, pin read and peripheral ownership
  task automatic t_port();
    wr(`GPCN_OFF_DIR, 16'hBF00);
    wr(`GPCN_OFF_PINVAL, 16'hC0A5);
    rd(`GPCN_OFF_LATCH, rd_val);
    check(rd_val, 16'h40A5);
    check(PIN_OE, 16'h40FF);
    PERIPH_ACTIVE <= 16'h4102;
    PERIPH_DATA <= 16'h0102;
    repeat (2) @(posedge CLK);
    rd(`GPCN_OFF_PINVAL, rd_val);
    check(rd_val, 16'h41A7);
    check(PIN_OE, 16'h41FF);
    check(PIN_OUT & IMPL, 16'h41A7);
    PERIPH_ACTIVE <= 16'h0000;
    repeat (2) @(posedge CLK);
    check(PIN_OUT & PIN_OE, 16'h40A5);
  endtask : t_port

  // Analog input pins: offered to the converter, read as zero
  task automatic t_analog();
    wr(`GPCN_OFF_DIR, 16'hFFF0);
    wr(`GPCN_OFF_ANALOG, 16'h00F0);
    ext_lvl <= 16'hFFFF;
    repeat (2) @(posedge CLK);
    check(ANALOG_SEL, 16'h00F0);
    rd(`GPCN_OFF_PINVAL, rd_val);
    check(rd_val, 16'h7F05);
  endtask : t_analog

  // Pull-ups, masked change, each input incl. one in sleep
  task automatic t_change();
    wr(`GPCN_OFF_ANALOG, 16'h0000);
    wr(`GPCN_OFF_DIR, IMPL);
    ext_lvl <= 16'h0000;
    wr(`GPCN_OFF_PULLUP, 16'h0002);
    check({8'h00, PULLUP_EN}, 16'h0002);
    wr(`GPCN_OFF_PULLUP, 16'h0000);
    wr(`GPCN_OFF_STATUS, 16'h0001);
    repeat (4) @(posedge CLK);
    check({15'h0000, CHANGE_IRQ}, 16'h0000);
    for (int i = 0; i < 8; i++)
    begin
      wr(`GPCN_OFF_CHG_EN, 16'h0001 << i);
      clk_run = (i != 3);
      #1;
      ext_lvl[i] <= 1'b1;
      #20;
      clk_run = 1'b1;
      wait_irq();
      rd(`GPCN_OFF_STATUS, rd_val);
      check(rd_val & 16'h0001, 16'h0001);
      wr(`GPCN_OFF_STATUS, 16'h0001);
      @(posedge CLK);
      check({15'h0000, CHANGE_IRQ}, 16'h0000);
    end
  endtask : t_change

  // Main sequence
  initial
  begin
    repeat (4) @(posedge CLK);
    RSTN <= 1'b1;
    @(posedge CLK);
    t_reset();
    t_port();
    t_analog();
    t_change();
    final_report();
  end
endmodule : gpcn_port_tb_top
